// >>> core/scs_clock_ctrl.sv
/*
  System clock source selection with fast RC postscaler, PLL and instruction
  clock divide. Oscillators are modelled as tick pulses synchronous to clk;
  registers sit on an Avalon-MM slave with waitrequest.
  Assumes configuration inputs are stable around reset release.
*/
// Our own choices: the register offsets and register access over Avalon-MM.
// Function
// - seven system clock choices: FAST_INTERNAL_RC, FAST_INTERNAL_RC+PLL, primary, primary+PLL, secondary, LOW_POWER_INTERNAL_RC, FAST_INTERNAL_RC postscaled.
// - fast RC runs at nominal 7.37 MHz, needs no external parts.
// - software tunes fast RC frequency through a tuning register.
// - 3-bit fast RC postscaler field picks divide ratio up to 1:256.
// - primary oscillator has crystal, high-speed crystal and external clock modes.
// - low-power RC at 32.768 kHz is watchdog and failure monitor reference.
// - at power-on reset, 3-bit source field and 2-bit mode field pick source.
// - erased configuration selects a fast RC based source.
// - configuration fields encode exactly twelve clock modes.
// - oscillator clock is PLL output in PLL modes, else chosen oscillator.
// - oscillator clock divided by two gives instruction and peripheral clocks.
// - only primary and fast RC may feed the PLL.
// - PLL input divided by prescale 2..33 from 5-bit field.
// - VCO input multiplied by factor from 9-bit feedback field.
// - VCO output divided by 2, 4 or 8 from 2-bit field.
// - PLL output equals input times feedback over prescale times postscale.
// - field codes are offset: prescale 0 gives 2, post 0 gives 2, 0x1E gives 32.
// - source codes 000..111: FAST_INTERNAL_RC, FAST_INTERNAL_RC PLL, primary, primary PLL, secondary, LOW_POWER_INTERNAL_RC, /16, /N.
// - mode 10 high speed, 01 crystal, 00 external; ignored for non-primary sources.
`timescale 1ns/10ps
`default_nettype none
module scs_clock_ctrl (
  input wire logic clk, // 100 MHz core clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [2:0] initial_source_select, // configuration source field
  input wire logic [1:0] primary_mode_select, // configuration primary mode field
  input wire logic fast_internal_rc_tick, // fast RC oscillator tick
  input wire logic primary_tick, // primary oscillator or external clock tick
  input wire logic secondary_low_power_crystal_tick, // secondary oscillator tick
  input wire logic low_power_internal_rc_tick, // low-power RC tick
  output logic [5:0] fast_rc_tune, // tuning code to the fast RC
  output logic primary_enable, // primary oscillator on
  output logic crystal_mode, // primary in crystal mode
  output logic high_speed_crystal_mode, // primary in high-speed crystal mode
  output logic external_clock_mode, // primary driven by external clock
  output logic secondary_enable, // secondary oscillator on
  output logic pll_enable, // pll in use
  output logic osc_tick, // oscillator clock tick
  output logic instr_tick, // instruction clock tick
  output logic peripheral_time_base, // peripheral clock tick
  output logic wdt_ref_tick // watchdog and clock_failure_monitor reference
);

  typedef enum logic [1:0] {
    SCS_BUS_IDLE = 2'b00,
    SCS_BUS_ACK = 2'b01
  } scs_bus_t;

  function automatic logic [8:0] frc_factor(input logic [2:0] code);
    frc_factor = (code == 3'h7) ? scs_pkg::FAST_RC_POSTSCALER_MAX_FACTOR : 9'(9'h1 << code);
  endfunction : frc_factor

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  scs_bus_t bus_st_r;
  logic access;
  logic [15:0] clock_divisor_register_r;
  logic [8:0] fbd_r;
  logic [15:0] fbd_merged;
  logic [5:0] tune_r;
  logic [31:0] rdata_r;
  logic taken_r;
  scs_pkg::scs_src_t src_r;
  logic [1:0] pmode_r;
  logic cfg_bad_r;
  logic [8:0] div_cnt_r;
  logic [8:0] div_factor;
  logic div_tick;
  logic pll_in_tick;
  logic pll_out_tick;
  logic pll_locked;
  logic src_tick;
  logic osc_tick_r;
  logic half_r;
  logic instr_tick_r;
  logic wdt_r;
  logic [15:0] status;
  logic primary_src;

  // bus slave: one wait cycle, then the answer on the second edge
  assign access = avs_read | avs_write;
  assign avs_waitrequest = access & (bus_st_r != SCS_BUS_ACK);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bus_st_r <= SCS_BUS_IDLE;
    else
    begin
      unique case (bus_st_r)
        SCS_BUS_IDLE: bus_st_r <= access ? SCS_BUS_ACK : SCS_BUS_IDLE;
        SCS_BUS_ACK: bus_st_r <= SCS_BUS_IDLE;
        default: bus_st_r <= SCS_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      clock_divisor_register_r <= scs_pkg::CD_RST;
    else if (avs_write && bus_st_r == SCS_BUS_ACK && avs_address == scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER)
      clock_divisor_register_r <= merge16(clock_divisor_register_r, avs_writedata, avs_byteenable) & scs_pkg::CD_WMASK;
  end

  // the merged word is a net so that the 9-bit field can be cut from it
  assign fbd_merged = merge16({7'h0, fbd_r}, avs_writedata, avs_byteenable);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fbd_r <= scs_pkg::FBD_RST;
    else if (avs_write && bus_st_r == SCS_BUS_ACK && avs_address == scs_pkg::ADDR_PLL_FEEDBACK_REGISTER)
      fbd_r <= fbd_merged[8:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tune_r <= scs_pkg::TUNE_RST;
    else if (avs_write && bus_st_r == SCS_BUS_ACK && avs_address == scs_pkg::ADDR_TUNE
             && avs_byteenable[0])
      tune_r <= avs_writedata[5:0];
  end

  assign status = {9'h0, cfg_bad_r, pll_locked, pmode_r, src_r};

  // read data stand at the edge where waitrequest is low
  always_comb
  begin
    unique case (avs_address)
      scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER: rdata_r = {16'h0, clock_divisor_register_r};
      scs_pkg::ADDR_PLL_FEEDBACK_REGISTER: rdata_r = {23'h0, fbd_r};
      scs_pkg::ADDR_TUNE: rdata_r = {26'h0, tune_r};
      scs_pkg::ADDR_STATUS: rdata_r = {16'h0, status};
      default: rdata_r = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0;
    else if (avs_read && bus_st_r == SCS_BUS_IDLE)
      avs_readdata <= rdata_r;
  end

  // configuration is caught by the first clocked edge after reset release
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      taken_r <= 1'b0;
    else
      taken_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      src_r <= scs_pkg::SCS_SRC_FRC;
      pmode_r <= scs_pkg::PM_EXT;
      cfg_bad_r <= 1'b0;
    end
    else if (!taken_r)
    begin
      // primary code 11 has no mode: fall back to fast RC, leaving twelve legal modes
      if ((initial_source_select == 3'h2 || initial_source_select == 3'h3)
          && primary_mode_select == 2'h3)
      begin
        src_r <= scs_pkg::SCS_SRC_FRC;
        cfg_bad_r <= 1'b1;
      end
      else
      begin
        src_r <= scs_pkg::scs_src_t'(initial_source_select);
        cfg_bad_r <= 1'b0;
      end
      pmode_r <= primary_mode_select;
    end
  end

  assign primary_src = (src_r == scs_pkg::SCS_SRC_PRI) || (src_r == scs_pkg::SCS_SRC_PRI_PLL);
  assign primary_enable = primary_src;
  assign crystal_mode = primary_src && pmode_r == scs_pkg::PM_XTAL;
  assign high_speed_crystal_mode = primary_src && pmode_r == scs_pkg::PM_HS;
  assign external_clock_mode = primary_src && pmode_r == scs_pkg::PM_EXT;
  assign secondary_enable = (src_r == scs_pkg::SCS_SRC_SEC);
  assign fast_rc_tune = tune_r;
  assign pll_enable = (src_r == scs_pkg::SCS_SRC_FRC_PLL) || (src_r == scs_pkg::SCS_SRC_PRI_PLL);

  // fast RC postscaler, fixed /16 or programmable /N
  assign div_factor = (src_r == scs_pkg::SCS_SRC_FRC_DIV16) ? 9'(scs_pkg::FRC_DIV16)
                    : frc_factor(clock_divisor_register_r[scs_pkg::CD_FAST_RC_POSTSCALER_LSB +: scs_pkg::CD_FAST_RC_POSTSCALER_W]);
  assign div_tick = fast_internal_rc_tick && (div_cnt_r >= div_factor - 9'h1);

  always_ff @(posedge clk)
  begin
    if (sys_rst || div_tick)
      div_cnt_r <= 9'h0;
    else if (fast_internal_rc_tick)
      div_cnt_r <= div_cnt_r + 9'h1;
  end

  assign pll_in_tick = (src_r == scs_pkg::SCS_SRC_PRI_PLL) ? primary_tick
                     : (src_r == scs_pkg::SCS_SRC_FRC_PLL) ? fast_internal_rc_tick : 1'b0;

  scs_pll_rate u_pll (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(pll_enable),
    .in_tick(pll_in_tick),
    .pre_code(clock_divisor_register_r[scs_pkg::CD_PRE_LSB +: scs_pkg::CD_PRE_W]),
    .fbd_code(fbd_r),
    .post_code(clock_divisor_register_r[scs_pkg::CD_POST_LSB +: scs_pkg::CD_POST_W]),
    .out_tick(pll_out_tick),
    .lock(pll_locked)
  );

  always_comb
  begin
    unique case (src_r)
      scs_pkg::SCS_SRC_FRC: src_tick = fast_internal_rc_tick;
      scs_pkg::SCS_SRC_FRC_PLL: src_tick = pll_out_tick;
      scs_pkg::SCS_SRC_PRI: src_tick = primary_tick;
      scs_pkg::SCS_SRC_PRI_PLL: src_tick = pll_out_tick;
      scs_pkg::SCS_SRC_SEC: src_tick = secondary_low_power_crystal_tick;
      scs_pkg::SCS_SRC_LOW_POWER_INTERNAL_RC: src_tick = low_power_internal_rc_tick;
      scs_pkg::SCS_SRC_FRC_DIV16: src_tick = div_tick;
      scs_pkg::SCS_SRC_FRC_DIVN: src_tick = div_tick;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || !taken_r)
      osc_tick_r <= 1'b0;
    else
      osc_tick_r <= src_tick;
  end

  // instruction and peripheral clocks tick on every second oscillator tick
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      half_r <= 1'b0;
      instr_tick_r <= 1'b0;
    end
    else
    begin
      if (osc_tick_r)
        half_r <= ~half_r;
      instr_tick_r <= osc_tick_r & half_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wdt_r <= 1'b0;
    else
      wdt_r <= low_power_internal_rc_tick;
  end

  assign osc_tick = osc_tick_r;
  assign instr_tick = instr_tick_r;
  assign peripheral_time_base = instr_tick_r;
  assign wdt_ref_tick = wdt_r;

  property p_wait_one;
    @(posedge clk) disable iff (sys_rst)
    $rose(access) && bus_st_r == SCS_BUS_IDLE |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait");

  property p_latch_src;
    @(posedge clk) disable iff (sys_rst)
    !taken_r && initial_source_select == 3'h7 |=> src_r == scs_pkg::SCS_SRC_FRC_DIVN;
  endproperty
  a_latch_src: assert property (p_latch_src) else $error("erased source not taken");

  property p_hold_src;
    @(posedge clk) disable iff (sys_rst)
    taken_r && $past(taken_r) |-> $stable(src_r) && $stable(pmode_r);
  endproperty
  a_hold_src: assert property (p_hold_src) else $error("source changed after latch");

  property p_pll_feed;
    @(posedge clk) disable iff (sys_rst)
    pll_in_tick |-> (fast_internal_rc_tick || primary_tick) && pll_enable;
  endproperty
  a_pll_feed: assert property (p_pll_feed) else $error("pll fed by wrong source");

  property p_pri_path;
    @(posedge clk) disable iff (sys_rst)
    taken_r && src_r == scs_pkg::SCS_SRC_PRI && primary_tick |=> osc_tick_r;
  endproperty
  a_pri_path: assert property (p_pri_path) else $error("primary tick not passed");

  property p_half;
    @(posedge clk) disable iff (sys_rst)
    instr_tick_r |-> $past(osc_tick_r) && !half_r ##1 !instr_tick_r;
  endproperty
  a_half: assert property (p_half) else $error("instruction clock not half rate");

  property p_wdt_ref;
    @(posedge clk) disable iff (sys_rst)
    low_power_internal_rc_tick |=> wdt_ref_tick;
  endproperty
  a_wdt_ref: assert property (p_wdt_ref) else $error("watchdog reference lost");

  property p_modes;
    @(posedge clk) disable iff (sys_rst)
    primary_enable |-> $onehot({crystal_mode, high_speed_crystal_mode, external_clock_mode});
  endproperty
  a_modes: assert property (p_modes) else $error("primary mode not unique");

  property p_div16;
    @(posedge clk) disable iff (sys_rst)
    src_r == scs_pkg::SCS_SRC_FRC_DIV16 && div_tick |-> div_cnt_r == 9'h00F;
  endproperty
  a_div16: assert property (p_div16) else $error("divide by 16 miscounted");

endmodule : scs_clock_ctrl
`default_nettype wire

// >>> include/scs_pkg.sv
/*
  Constants for the system clock source and PLL selection block: register map,
  field positions, reset values, source and mode encodings, divisor offsets.
  Assumes a single 100 MHz core clock; oscillator activity arrives as tick pulses.
*/
package scs_pkg;

  // clock period, used only to document the tick rate
  localparam int CLK_PERIOD_NS = 10;

  // register byte addresses
  localparam logic [3:0] ADDR_CLOCK_DIVISOR_REGISTER = 4'h0;
  localparam logic [3:0] ADDR_PLL_FEEDBACK_REGISTER = 4'h4;
  localparam logic [3:0] ADDR_TUNE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // clock_divisor_register fields
  localparam int CD_PRE_LSB = 0;
  localparam int CD_PRE_W = 5;
  localparam int CD_POST_LSB = 6;
  localparam int CD_POST_W = 2;
  localparam int CD_FAST_RC_POSTSCALER_LSB = 8;
  localparam int CD_FAST_RC_POSTSCALER_W = 3;
  localparam int CD_DOZEN_BIT = 11;
  localparam int CD_DOZE_LSB = 12;
  localparam int CD_ROI_BIT = 15;
  localparam logic [15:0] CD_RST = 16'h3040;
  localparam logic [15:0] CD_WMASK = 16'hFFDF;

  // pll_feedback_register
  localparam int FBD_W = 9;
  localparam logic [8:0] FBD_RST = 9'h01E;

  // fast RC tuning register
  localparam int TUNE_W = 6;
  localparam logic [5:0] TUNE_RST = 6'h00;

  // status register fields
  localparam int ST_SRC_LSB = 0;
  localparam int ST_MODE_LSB = 3;
  localparam int ST_LOCK_BIT = 5;
  localparam int ST_BAD_BIT = 6;

  // initial_source_select encodings
  typedef enum logic [2:0] {
    SCS_SRC_FRC = 3'h0,
    SCS_SRC_FRC_PLL = 3'h1,
    SCS_SRC_PRI = 3'h2,
    SCS_SRC_PRI_PLL = 3'h3,
    SCS_SRC_SEC = 3'h4,
    SCS_SRC_LOW_POWER_INTERNAL_RC = 3'h5,
    SCS_SRC_FRC_DIV16 = 3'h6,
    SCS_SRC_FRC_DIVN = 3'h7
  } scs_src_t;

  // primary_mode_select encodings; 11 is not a valid primary mode
  localparam logic [1:0] PM_EXT = 2'h0;
  localparam logic [1:0] PM_XTAL = 2'h1;
  localparam logic [1:0] PM_HS = 2'h2;

  // divisor offsets and fixed divides
  localparam int PRE_OFFSET = 2;
  localparam int FBD_OFFSET = 2;
  localparam int FRC_DIV16 = 16;
  localparam logic [8:0] FAST_RC_POSTSCALER_MAX_FACTOR = 9'h100;

  // PLL input ticks seen before lock is reported
  localparam logic [7:0] PLL_LOCK_TICKS = 8'h10;

endpackage : scs_pkg

// >>> core/scs_pll_rate.sv
/*
  Rate model of the on-chip PLL: output tick rate is input rate times M over N1*N2.
  Assumes input ticks are one-cycle pulses synchronous to clk; at most one output
  tick per clock, so the synthesised rate saturates at the core clock rate.
*/
`timescale 1ns/10ps
`default_nettype none
module scs_pll_rate (
  input wire logic clk, // core clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic enable, // pll selected
  input wire logic in_tick, // pll_input_clock tick
  input wire logic [4:0] pre_code, // pll_prescaler_field
  input wire logic [8:0] fbd_code, // pll_feedback_field
  input wire logic [1:0] post_code, // pll_postscaler_field
  output logic out_tick, // pll output tick
  output logic lock // lock status
);

  function automatic logic [9:0] post_factor(input logic [1:0] code);
    unique case (code)
      2'h0: post_factor = 10'd2;
      2'h1: post_factor = 10'd4;
      default: post_factor = 10'd8;
    endcase
  endfunction : post_factor

  logic [9:0] m_val;
  logic [9:0] n1_val;
  logic [15:0] den;
  logic [17:0] acc_r;
  logic [17:0] acc_sum;
  logic [7:0] lock_cnt_r;
  logic [15:0] cfg_q_r;
  logic out_tick_r;

  assign m_val = 10'(fbd_code) + 10'(scs_pkg::FBD_OFFSET);
  assign n1_val = 10'(pre_code) + 10'(scs_pkg::PRE_OFFSET);
  assign den = 16'(n1_val * post_factor(post_code));
  assign acc_sum = acc_r + (in_tick ? 18'(m_val) : 18'h0);

  // fractional accumulator: out rate = in rate * M / (N1 * N2)
  always_ff @(posedge clk)
  begin
    if (sys_rst || !enable)
    begin
      acc_r <= 18'h0;
      out_tick_r <= 1'b0;
    end
    else if (acc_sum >= 18'(den))
    begin
      acc_r <= acc_sum - 18'(den);
      out_tick_r <= lock;
    end
    else
    begin
      acc_r <= acc_sum;
      out_tick_r <= 1'b0;
    end
  end

  // lock restarts whenever a divisor changes, as a real loop would relock
  always_ff @(posedge clk)
  begin
    if (sys_rst || !enable || cfg_q_r != {pre_code, fbd_code, post_code})
      lock_cnt_r <= 8'h0;
    else if (in_tick && lock_cnt_r != scs_pkg::PLL_LOCK_TICKS)
      lock_cnt_r <= lock_cnt_r + 8'h1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfg_q_r <= 16'h0;
    else
      cfg_q_r <= {pre_code, fbd_code, post_code};
  end

  assign lock = (lock_cnt_r == scs_pkg::PLL_LOCK_TICKS);
  assign out_tick = out_tick_r;

  property p_out_locked;
    @(posedge clk) disable iff (sys_rst)
    out_tick |-> $past(lock) && $past(enable);
  endproperty
  a_out_locked: assert property (p_out_locked) else $error("pll tick without lock");

  property p_no_tick_disabled;
    @(posedge clk) disable iff (sys_rst)
    !enable |=> !out_tick;
  endproperty
  a_no_tick_disabled: assert property (p_no_tick_disabled) else $error("pll tick while disabled");

endmodule : scs_pll_rate
`default_nettype wire

// >>> verification/scs_osc_model.sv
/*
  Oscillator tick source for the clock control bench: four dividers of clk,
  each a one-cycle pulse. Assumes the bench gates all of them with run.
*/
`timescale 1ns/10ps
`default_nettype none
module scs_osc_model #(
  parameter int FRC_P = 5,
  parameter int PRI_P = 3,
  parameter int SEC_P = 40,
  parameter int LP_P = 50
) (
  input wire logic clk, // core clock
  input wire logic run, // oscillators running
  output var logic frc_tick = 1'b0, // fast RC tick
  output var logic pri_tick = 1'b0, // primary crystal or external clock tick
  output var logic sec_tick = 1'b0, // secondary crystal tick
  output var logic lp_tick = 1'b0 // low-power RC tick
);
  int n_r = 0;
  // a stopped oscillator gives no edges at all, so every tick holds low
  always @(posedge clk)
  begin
    n_r <= run ? n_r + 1 : n_r;
    frc_tick <= run && (n_r % FRC_P == 0);
    pri_tick <= run && (n_r % PRI_P == 0);
    sec_tick <= run && (n_r % SEC_P == 0);
    lp_tick <= run && (n_r % LP_P == 0);
  end
endmodule : scs_osc_model
`default_nettype wire

// >>> verification/tb_top.sv
/*
  Self-checking bench for the clock source block: Avalon-MM register tasks,
  power-on configuration sweep by repeated reset, tick rate counts.
  Assumes scs_pkg and the oscillator tick model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] src_cfg = 3'h0;
  logic [1:0] mode_cfg = 2'h0;
  logic run = 1'b0;
  logic cnt_clr = 1'b0;
  logic frc_tick, pri_tick, sec_tick, lp_tick;
  logic [5:0] fast_rc_tune;
  logic primary_enable, crystal_mode, high_speed_crystal_mode, external_clock_mode, secondary_enable, pll_enable;
  logic osc_tick, instr_tick, peripheral_time_base, wdt_ref_tick;
  int c_frc = 0, c_pri = 0, c_sec = 0, c_lp = 0, c_osc = 0, c_instr = 0, c_ptb = 0, c_wdt = 0;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] q;
  logic [5:0] en;
  logic pri;

  scs_osc_model scs_osc_model_i (.clk(clk), .run(run), .frc_tick(frc_tick), .pri_tick(pri_tick),
    .sec_tick(sec_tick), .lp_tick(lp_tick));

  scs_clock_ctrl scs_clock_ctrl_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .initial_source_select(src_cfg), .primary_mode_select(mode_cfg), .fast_internal_rc_tick(frc_tick),
    .primary_tick(pri_tick), .secondary_low_power_crystal_tick(sec_tick),
    .low_power_internal_rc_tick(lp_tick), .fast_rc_tune(fast_rc_tune), .primary_enable(primary_enable),
    .crystal_mode(crystal_mode), .high_speed_crystal_mode(high_speed_crystal_mode),
    .external_clock_mode(external_clock_mode), .secondary_enable(secondary_enable),
    .pll_enable(pll_enable), .osc_tick(osc_tick), .instr_tick(instr_tick),
    .peripheral_time_base(peripheral_time_base), .wdt_ref_tick(wdt_ref_tick));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // counts are cleared by reset so that divider phases start together with them
  always @(posedge clk)
  begin
    if (sys_rst || cnt_clr)
    begin
      {c_frc, c_pri, c_sec, c_lp} <= '0;
      {c_osc, c_instr, c_ptb, c_wdt} <= '0;
    end
    else
    begin
      c_frc <= c_frc + int'(frc_tick);
      c_pri <= c_pri + int'(pri_tick);
      c_sec <= c_sec + int'(sec_tick);
      c_lp <= c_lp + int'(lp_tick);
      c_osc <= c_osc + int'(osc_tick);
      c_instr <= c_instr + int'(instr_tick);
      c_ptb <= c_ptb + int'(peripheral_time_base);
      c_wdt <= c_wdt + int'(wdt_ref_tick);
    end
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check_val

  task automatic check_rng(input string nm, input int lo, input int hi, input int s);
    n_compared++;
    if (s < lo || s > hi)
    begin
      err_total++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask : check_rng

  // entered just after a rising edge; sampled right at each edge, before the design's updates land there
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
    output logic [31:0] r);
    int k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (wr)
      avs_write <= 1'b1;
    else
      avs_read <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    r = avs_readdata;
    if (avs_waitrequest !== 1'b0)
      check_val("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : av_xfer

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] dummy;
    av_xfer(1'b1, a, d, be, dummy);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    av_xfer(1'b0, a, 32'h0, 4'hF, r);
    check_val(nm, e & m, r & m);
  endtask : rd_chk

  // configuration is moved away two edges after release: it must already be latched by then
  task automatic do_reset(input logic [2:0] s, input logic [1:0] m);
    run <= 1'b0;
    sys_rst <= 1'b1;
    src_cfg <= s;
    mode_cfg <= m;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    src_cfg <= ~s;
    mode_cfg <= ~m;
    @(posedge clk);
  endtask : do_reset

  task automatic meas(input int cyc);
    cnt_clr <= 1'b1;
    run <= 1'b1;
    @(posedge clk);
    cnt_clr <= 1'b0;
    repeat (cyc) @(posedge clk);
    run <= 1'b0;
    repeat (16) @(posedge clk);
  endtask : meas

  function automatic int exp_osc(input logic [2:0] s);
    case (s)
      3'h0, 3'h7: return c_frc;
      3'h2: return c_pri;
      3'h4: return c_sec;
      3'h5: return c_lp;
      3'h6: return c_frc / 16;
      default: return -1;
    endcase
  endfunction : exp_osc

  initial
  begin
    #500000;
    check_val("watchdog", 32'h0, 32'h1);
    finish_test;
  end

  initial
  begin
    do_reset(3'h7, 2'h3);
    rd_chk("status_erased", scs_pkg::ADDR_STATUS, 32'h7, 32'hFFFF_FFE7);
    rd_chk("clock_divisor_register_rst", scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER, 32'h0000_3040, 32'hFFFF_FFFF);
    rd_chk("fbd_rst", scs_pkg::ADDR_PLL_FEEDBACK_REGISTER, 32'h0000_001E, 32'hFFFF_FFFF);
    rd_chk("tune_rst", scs_pkg::ADDR_TUNE, 32'h0, 32'hFFFF_FFFF);
    wr(scs_pkg::ADDR_TUNE, 32'h0000_002A, 4'h1);
    rd_chk("tune", scs_pkg::ADDR_TUNE, 32'h0000_002A, 32'hFFFF_FFFF);
    check_val("fast_rc_tune", 32'h2A, {26'h0, fast_rc_tune});
    wr(scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER, 32'hFFFF_FFFF, 4'hF);
    rd_chk("clock_divisor_register_all", scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER, 32'h0000_FFDF, 32'hFFFF_FFFF);
    wr(scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER, 32'h0000_AB12, 4'h1);
    rd_chk("clock_divisor_register_lane0", scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER, 32'h0000_FF12, 32'hFFFF_FFFF);
    wr(scs_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
    rd_chk("status_ro", scs_pkg::ADDR_STATUS, 32'h7, 32'hFFFF_FFE7);
    wr(4'h2, 32'hFFFF_FFFF, 4'hF);
    rd_chk("unmapped", 4'h2, 32'h0, 32'hFFFF_FFFF);
    $display("test registers done");
    for (int k = 0; k < 2; k++)
    begin
      do_reset(3'h7, 2'h0);
      wr(scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER, {16'h0000, scs_pkg::CD_RST} | (k ? 32'h0000_0700 : 32'h0000_0300), 4'h3);
      meas(4000);
      check_val("osc_div_n", c_frc / (k ? 256 : 8), c_osc);
    end
    $display("test fast rc postscaler done");
    for (int s = 0; s < 8; s++)
    begin
      for (int m = 0; m < 4; m++)
      begin
        do_reset(3'(s), 2'(m));
        pri = (s == 2 || s == 3) && m != 3;
        en = {pri, pri && m == 1, pri && m == 2, pri && m == 0, s == 4, s == 1 || (s == 3 && pri)};
        q = {25'h0, (s == 2 || s == 3) && m == 3, 1'b0, 2'(m), pri || s > 3 || s < 2 ? 3'(s) : 3'h0};
        rd_chk("status_src", scs_pkg::ADDR_STATUS, q, pri ? 32'hFFFF_FFFF : 32'hFFFF_FFE7);
        check_val("enables", {26'h0, en}, {26'h0, primary_enable, crystal_mode, high_speed_crystal_mode,
          external_clock_mode, secondary_enable, pll_enable});
        if (en[0] === 1'b0)
        begin
          meas(600);
          check_val("osc_count", exp_osc(q[2:0]), c_osc);
          check_val("instr_count", c_osc / 2, c_instr);
          check_val("periph_count", c_instr, c_ptb);
          check_val("wdt_ref_count", c_lp, c_wdt);
        end
      end
    end
    $display("test source sweep done");
    // divisors keep vco input, vco output and pll output inside their bands at the nominal rates
    do_reset(3'h1, 2'h0);
    meas(400);
    rd_chk("pll_lock", scs_pkg::ADDR_STATUS, 32'h20, 32'h20);
    meas(1000);
    check_rng("pll_x4", 4 * c_frc - 8, 4 * c_frc + 8, c_osc);
    check_rng("pll_instr", c_osc / 2, (c_osc + 1) / 2, c_instr);
    wr(scs_pkg::ADDR_CLOCK_DIVISOR_REGISTER, 32'h0000_3081, 4'h3);
    wr(scs_pkg::ADDR_PLL_FEEDBACK_REGISTER, 32'h0000_002E, 4'h3);
    rd_chk("pll_relock", scs_pkg::ADDR_STATUS, 32'h0, 32'h20);
    meas(400);
    meas(1000);
    check_rng("pll_x2", 2 * c_frc - 8, 2 * c_frc + 8, c_osc);
    $display("test pll done");
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
